// ==== pkg/rwrb_pkg.sv ====
// package: register indices, slot layout, reset values and field positions of the runtime block
package rwrb_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] RWRB_IDX_WAKE_STS = 8'h00;
	localparam logic [7:0] RWRB_IDX_WAKE_EN = 8'h02;
	localparam logic [7:0] RWRB_IDX_DEV_DIS = 8'h21;
	localparam logic [7:0] RWRB_IDX_GPIO43 = 8'h3E;
	localparam logic [7:0] RWRB_IDX_GPIO3 = 8'h4D;
	localparam logic [7:0] RWRB_IDX_GPIO6 = 8'h50;
	localparam logic [7:0] RWRB_IDX_WDT_TMO = 8'h52;
	localparam logic [7:0] RWRB_IDX_WDT_COUNT = 8'h53;
	localparam logic [7:0] RWRB_IDX_WDT_SETUP = 8'h54;
	localparam logic [7:0] RWRB_IDX_WDT_CONTROL = 8'h55;
	localparam logic [7:0] RWRB_IDX_FAN = 8'h56;
	localparam logic [7:0] RWRB_IDX_FAN_CTRL = 8'h58;
	localparam logic [7:0] RWRB_IDX_FAN_TACH = 8'h59;
	localparam logic [7:0] RWRB_IDX_FAN_PRE = 8'h5B;
	localparam logic [7:0] RWRB_IDX_IND1 = 8'h5D;
	localparam logic [7:0] RWRB_IDX_IND2 = 8'h5E;
	localparam logic [7:0] RWRB_IDX_KEY = 8'h5F;
	localparam logic [7:0] RWRB_IDX_PM1 = 8'h60;
	localparam logic [7:0] RWRB_IDX_PM2 = 8'h61;
	localparam logic [7:0] RWRB_IDX_SMGT_STS7 = 8'h64;
	localparam logic [7:0] RWRB_IDX_SMGT_EN7 = 8'h66;
	localparam logic [7:0] RWRB_IDX_WAKE_STS7 = 8'h68;
	localparam logic [7:0] RWRB_IDX_WAKE_EN7 = 8'h6C;
	localparam logic [7:0] RWRB_IDX_PORT_ACT = 8'h80;
	localparam logic [7:0] RWRB_IDX_IRQ_STS = 8'h81;
	localparam logic [7:0] RWRB_IDX_IRQ_MASK = 8'h82;
	localparam logic [7:0] RWRB_IDX_MAX = 8'h82;
	localparam logic [7:0] RWRB_IDX_RSVD = 8'h51;
	// storage slots of the read/write registers, including write-one-to-clear RWRB_S_WAKE_STS7 and lockable RWRB_S_DEV_DIS
	localparam int RWRB_NSLOT = 22;
	localparam logic [4:0] RWRB_S_GPIO6 = 5'h00;
	localparam logic [4:0] RWRB_S_WDT_TMO = 5'h01;
	localparam logic [4:0] RWRB_S_WDT_COUNT = 5'h02;
	localparam logic [4:0] RWRB_S_WDT_SETUP = 5'h03;
	localparam logic [4:0] RWRB_S_WDT_CONTROL = 5'h04;
	localparam logic [4:0] RWRB_S_FAN = 5'h05;
	localparam logic [4:0] RWRB_S_FAN_CTRL = 5'h06;
	localparam logic [4:0] RWRB_S_FAN_PRE = 5'h07;
	localparam logic [4:0] RWRB_S_IND1 = 5'h08;
	localparam logic [4:0] RWRB_S_IND2 = 5'h09;
	localparam logic [4:0] RWRB_S_KEY = 5'h0A;
	localparam logic [4:0] RWRB_S_PM1 = 5'h0B;
	localparam logic [4:0] RWRB_S_PM2 = 5'h0C;
	localparam logic [4:0] RWRB_S_SMGT_STS7 = 5'h0D;
	localparam logic [4:0] RWRB_S_SMGT_EN7 = 5'h0E;
	localparam logic [4:0] RWRB_S_WAKE_STS7 = 5'h0F;
	localparam logic [4:0] RWRB_S_WAKE_EN7 = 5'h10;
	localparam logic [4:0] RWRB_S_DEV_DIS = 5'h11;
	localparam logic [4:0] RWRB_S_GPIO43 = 5'h12;
	localparam logic [4:0] RWRB_S_GPIO3 = 5'h13;
	localparam logic [4:0] RWRB_S_PORT_ACT = 5'h14;
	localparam logic [4:0] RWRB_S_IRQ_MASK = 5'h15;
	localparam logic [4:0] RWRB_S_NONE = 5'h1F;
	// reset values on standby power-on reset
	localparam logic [7:0] RWRB_RST_ZERO = 8'h00;
	localparam logic [7:0] RWRB_RST_FAN_CTRL = 8'h10;
	localparam logic [7:0] RWRB_RST_GPIO43 = 8'h01;
	// field positions
	localparam int RWRB_B_WAKE = 0;
	localparam int RWRB_B_WDT_KEEP = 0;
	localparam int RWRB_B_FAN_OUT = 3;
	localparam int RWRB_B_G43_LO = 2;
	localparam int RWRB_B_G43_HI = 3;
	localparam logic [1:0] RWRB_G43_LOCK = 2'b01;
	localparam int RWRB_B_PORT_ACT = 0;
	localparam int RWRB_NIRQ = 2;
	localparam int RWRB_IRQ_WAKE = 0;
	localparam int RWRB_IRQ_EDGE = 1;
	// bus responses
	localparam logic [1:0] RWRB_RESP_OKAY = 2'b00;
	localparam logic [1:0] RWRB_RESP_SLVERR = 2'b10;

	function automatic logic [4:0] rwrb_slot_of(input logic [7:0] idx);
		case (idx)
			RWRB_IDX_GPIO6: rwrb_slot_of = RWRB_S_GPIO6;
			RWRB_IDX_WDT_TMO: rwrb_slot_of = RWRB_S_WDT_TMO;
			RWRB_IDX_WDT_COUNT: rwrb_slot_of = RWRB_S_WDT_COUNT;
			RWRB_IDX_WDT_SETUP: rwrb_slot_of = RWRB_S_WDT_SETUP;
			RWRB_IDX_WDT_CONTROL: rwrb_slot_of = RWRB_S_WDT_CONTROL;
			RWRB_IDX_FAN: rwrb_slot_of = RWRB_S_FAN;
			RWRB_IDX_FAN_CTRL: rwrb_slot_of = RWRB_S_FAN_CTRL;
			RWRB_IDX_FAN_PRE: rwrb_slot_of = RWRB_S_FAN_PRE;
			RWRB_IDX_IND1: rwrb_slot_of = RWRB_S_IND1;
			RWRB_IDX_IND2: rwrb_slot_of = RWRB_S_IND2;
			RWRB_IDX_KEY: rwrb_slot_of = RWRB_S_KEY;
			RWRB_IDX_PM1: rwrb_slot_of = RWRB_S_PM1;
			RWRB_IDX_PM2: rwrb_slot_of = RWRB_S_PM2;
			RWRB_IDX_SMGT_STS7: rwrb_slot_of = RWRB_S_SMGT_STS7;
			RWRB_IDX_SMGT_EN7: rwrb_slot_of = RWRB_S_SMGT_EN7;
			RWRB_IDX_WAKE_STS7: rwrb_slot_of = RWRB_S_WAKE_STS7;
			RWRB_IDX_WAKE_EN7: rwrb_slot_of = RWRB_S_WAKE_EN7;
			RWRB_IDX_DEV_DIS: rwrb_slot_of = RWRB_S_DEV_DIS;
			RWRB_IDX_GPIO43: rwrb_slot_of = RWRB_S_GPIO43;
			RWRB_IDX_GPIO3: rwrb_slot_of = RWRB_S_GPIO3;
			RWRB_IDX_PORT_ACT: rwrb_slot_of = RWRB_S_PORT_ACT;
			RWRB_IDX_IRQ_MASK: rwrb_slot_of = RWRB_S_IRQ_MASK;
			default: rwrb_slot_of = RWRB_S_NONE;
		endcase
	endfunction
endpackage

// ==== hdl/rwrb_core.sv ====
// runtime wake register block: AXI4-Lite slave, wake request pin, reset-domain exceptions
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps

module rwrb_core (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mainPorIn,
	input wire logic hardRstIn,
	input wire logic wakeEventIn,
	input wire logic [7:0] wakeSourceIn,
	input wire logic [7:0] fanTachCountIn,
	input wire logic gpioPin43,
	input wire logic printerAcknowledgeN,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wakeRequestPinN,
	output logic printerPortIrq,
	output logic fanOutputLevel,
	output logic [7:0] watchdogControl,
	output logic irq
);
	import rwrb_pkg::*;

	typedef struct packed {
		logic awHeld;
		logic [7:0] awIdx;
		logic awBad;
		logic wHeld;
		logic [7:0] wData;
		logic wLane;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [7:0] rData;
		logic [1:0] rResp;
		logic [RWRB_NSLOT-1:0][7:0] slot;
		logic wakeFlag;
		logic wakeGate;
		logic [RWRB_NIRQ-1:0] irqSts;
		logic pinSync1;
		logic pinSync2;
		logic pinLast;
		logic [2:0] pinWarm;
		logic ackSync1;
		logic ackSync2;
	} rwrb_state_t;

	localparam logic [RWRB_NSLOT-1:0][7:0] SLOT_RESET = {
		RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_GPIO43,
		RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO,
		RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO,
		RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_FAN_CTRL,
		RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO, RWRB_RST_ZERO,
		RWRB_RST_ZERO, RWRB_RST_ZERO};
	localparam rwrb_state_t STATE_RESET = '{slot: SLOT_RESET, default: '0};

	rwrb_state_t s_ff;
	rwrb_state_t nxt_s;
	logic wrFire;
	logic wrOne;
	logic rdFire;
	logic pinEdge;
	logic wakeSet;
	logic devLocked;
	logic [7:0] rdIdx;
	logic [7:0] rdValue;
	logic [4:0] wrSlot;
	logic [4:0] rdSlot;

	////////////////////////////////////////////////////////////////////////////////
	// bus handshakes and decode

	assign s_axi_awready = !s_ff.awHeld && !s_ff.bValid;
	assign s_axi_wready = !s_ff.wHeld && !s_ff.bValid;
	assign s_axi_arready = !s_ff.rValid;
	assign s_axi_bvalid = s_ff.bValid;
	assign s_axi_bresp = s_ff.bResp;
	assign s_axi_rvalid = s_ff.rValid;
	assign s_axi_rresp = s_ff.rResp;
	assign s_axi_rdata = {24'h000000, s_ff.rData};
	assign wrFire = s_ff.awHeld && s_ff.wHeld && !s_ff.bValid;
	assign wrOne = wrFire && !s_ff.awBad && s_ff.wLane;
	assign rdFire = s_axi_arvalid && !s_ff.rValid;
	assign rdIdx = s_axi_araddr[9:2];
	assign wrSlot = rwrb_slot_of(s_ff.awIdx);
	assign rdSlot = rwrb_slot_of(rdIdx);
	// either edge of the synchronised pin, polarity bit not involved
	assign pinEdge = (s_ff.pinSync2 ^ s_ff.pinLast) && s_ff.pinWarm[2];
	assign wakeSet = wakeEventIn || |(s_ff.slot[RWRB_S_WAKE_STS7] & s_ff.slot[RWRB_S_WAKE_EN7]);
	assign devLocked = (s_ff.slot[RWRB_S_GPIO43][RWRB_B_G43_HI:RWRB_B_G43_LO] == RWRB_G43_LOCK)
		&& s_ff.pinSync2;

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wakeRequestPinN = !(s_ff.wakeFlag && s_ff.wakeGate);
	assign printerPortIrq = s_ff.slot[RWRB_S_PORT_ACT][RWRB_B_PORT_ACT] ? s_ff.ackSync2 : 1'b1;
	assign fanOutputLevel = s_ff.slot[RWRB_S_GPIO3][RWRB_B_FAN_OUT];
	assign watchdogControl = s_ff.slot[RWRB_S_WDT_CONTROL];
	assign irq = |(s_ff.irqSts & s_ff.slot[RWRB_S_IRQ_MASK][RWRB_NIRQ-1:0]);

	////////////////////////////////////////////////////////////////////////////////
	// read mux; unlisted locations read zero

	always_comb begin
		rdValue = 8'h00;
		if (rdIdx == RWRB_IDX_WAKE_STS) begin
			rdValue[RWRB_B_WAKE] = s_ff.wakeFlag;
		end else if (rdIdx == RWRB_IDX_WAKE_EN) begin
			rdValue[RWRB_B_WAKE] = s_ff.wakeGate;
		end else if (rdIdx == RWRB_IDX_FAN_TACH) begin
			rdValue = fanTachCountIn;
		end else if (rdIdx == RWRB_IDX_IRQ_STS) begin
			rdValue[RWRB_NIRQ-1:0] = s_ff.irqSts;
		end else if (rdIdx == RWRB_IDX_PORT_ACT) begin
			rdValue[RWRB_B_PORT_ACT] = s_ff.slot[RWRB_S_PORT_ACT][RWRB_B_PORT_ACT];
		end else if (rdIdx == RWRB_IDX_IRQ_MASK) begin
			rdValue[RWRB_NIRQ-1:0] = s_ff.slot[RWRB_S_IRQ_MASK][RWRB_NIRQ-1:0];
		end else if (rdSlot != RWRB_S_NONE) begin
			rdValue = s_ff.slot[rdSlot];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_s = s_ff;
		nxt_s.pinSync1 = gpioPin43;
		nxt_s.pinSync2 = s_ff.pinSync1;
		nxt_s.pinLast = s_ff.pinSync2;
		nxt_s.pinWarm = {s_ff.pinWarm[1:0], 1'b1};
		nxt_s.ackSync1 = printerAcknowledgeN;
		nxt_s.ackSync2 = s_ff.ackSync1;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_s.awHeld = 1'b1;
			nxt_s.awIdx = s_axi_awaddr[9:2];
			nxt_s.awBad = (s_axi_awaddr[31:10] != 22'h000000) || (s_axi_awaddr[9:2] > RWRB_IDX_MAX);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_s.wHeld = 1'b1;
			nxt_s.wData = s_axi_wdata[7:0];
			nxt_s.wLane = s_axi_wstrb[0];
		end
		if (s_ff.bValid && s_axi_bready) begin
			nxt_s.bValid = 1'b0;
		end
		if (wrFire) begin
			nxt_s.awHeld = 1'b0;
			nxt_s.wHeld = 1'b0;
			nxt_s.bValid = 1'b1;
			nxt_s.bResp = s_ff.awBad ? RWRB_RESP_SLVERR : RWRB_RESP_OKAY;
		end
		// register writes
		if (wrOne) begin
			if (s_ff.awIdx == RWRB_IDX_WAKE_STS && s_ff.wData[RWRB_B_WAKE]) begin
				nxt_s.wakeFlag = 1'b0;
			end
			if (s_ff.awIdx == RWRB_IDX_WAKE_EN) begin
				nxt_s.wakeGate = s_ff.wData[RWRB_B_WAKE];
			end
			if (s_ff.awIdx == RWRB_IDX_IRQ_STS) begin
				nxt_s.irqSts = s_ff.irqSts & ~s_ff.wData[RWRB_NIRQ-1:0];
			end
			if (s_ff.awIdx == RWRB_IDX_WAKE_STS7) begin
				nxt_s.slot[RWRB_S_WAKE_STS7] = s_ff.slot[RWRB_S_WAKE_STS7] & ~s_ff.wData;
			end else if (s_ff.awIdx == RWRB_IDX_DEV_DIS) begin
				if (!devLocked) begin
					nxt_s.slot[RWRB_S_DEV_DIS] = s_ff.wData;
				end
			end else if (wrSlot != RWRB_S_NONE) begin
				nxt_s.slot[wrSlot] = s_ff.wData;
			end
		end
		// hardware sets win over software clears
		nxt_s.slot[RWRB_S_WAKE_STS7] = nxt_s.slot[RWRB_S_WAKE_STS7] | wakeSourceIn;
		if (wakeSet) begin
			nxt_s.wakeFlag = 1'b1;
			nxt_s.irqSts[RWRB_IRQ_WAKE] = 1'b1;
		end
		if (pinEdge) begin
			nxt_s.irqSts[RWRB_IRQ_EDGE] = 1'b1;
		end
		// main power-on and hard reset; wake flag and gate untouched
		if (mainPorIn || hardRstIn) begin
			nxt_s.slot[RWRB_S_WDT_TMO] = RWRB_RST_ZERO;
			nxt_s.slot[RWRB_S_WDT_COUNT] = RWRB_RST_ZERO;
			nxt_s.slot[RWRB_S_WDT_SETUP] = RWRB_RST_ZERO;
			nxt_s.slot[RWRB_S_GPIO3][RWRB_B_FAN_OUT] = 1'b0;
			nxt_s.slot[RWRB_S_GPIO43][RWRB_B_G43_HI:RWRB_B_G43_LO] = 2'b00;
			if (mainPorIn) begin
				nxt_s.slot[RWRB_S_WDT_CONTROL] = RWRB_RST_ZERO;
			end else begin
				nxt_s.slot[RWRB_S_WDT_CONTROL] =
					{7'h00, s_ff.slot[RWRB_S_WDT_CONTROL][RWRB_B_WDT_KEEP]};
			end
		end
		// read response
		if (s_ff.rValid && s_axi_rready) begin
			nxt_s.rValid = 1'b0;
		end
		if (rdFire) begin
			nxt_s.rValid = 1'b1;
			nxt_s.rData = rdValue;
			nxt_s.rResp = ((s_axi_araddr[31:10] != 22'h000000) || (rdIdx > RWRB_IDX_MAX)) ?
				RWRB_RESP_SLVERR : RWRB_RESP_OKAY;
		end
	end

	// sys_rst is the standby power-on reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_ff <= STATE_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_wake_set;
		@(posedge clk) disable iff (sys_rst)
		wakeEventIn |=> s_ff.wakeFlag;
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake flag not set by event");

	property p_wake_clear;
		@(posedge clk) disable iff (sys_rst)
		(wrOne && s_ff.awIdx == RWRB_IDX_WAKE_STS && s_ff.wData[RWRB_B_WAKE] && !wakeSet)
		|=> !s_ff.wakeFlag && wakeRequestPinN;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake flag not cleared by one");

	property p_wake_zero;
		@(posedge clk) disable iff (sys_rst)
		(wrOne && s_ff.awIdx == RWRB_IDX_WAKE_STS && !s_ff.wData[RWRB_B_WAKE])
		|=> s_ff.wakeFlag == $past(s_ff.wakeFlag) || $past(wakeSet);
	endproperty
	a_wake_zero: assert property (p_wake_zero) else $error("zero write changed wake flag");

	property p_flag_keep;
		@(posedge clk) disable iff (sys_rst)
		((mainPorIn || hardRstIn) && !wrOne && !wakeSet) |=> $stable(s_ff.wakeFlag);
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("wake flag lost on reset");

	property p_gate_block;
		@(posedge clk) disable iff (sys_rst)
		!s_ff.wakeGate |-> wakeRequestPinN;
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("wake pin asserted with gate shut");

	property p_gate_keep;
		@(posedge clk) disable iff (sys_rst)
		((mainPorIn || hardRstIn) && !wrOne) |=> $stable(s_ff.wakeGate);
	endproperty
	a_gate_keep: assert property (p_gate_keep) else $error("wake gate lost on reset");

	property p_rsvd_zero;
		@(posedge clk) disable iff (sys_rst)
		(rdFire && s_axi_araddr == {22'h000000, RWRB_IDX_RSVD, 2'b00}) |=> s_axi_rvalid && s_axi_rdata == 32'h00000000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved location not zero");

	property p_wdt_keep;
		@(posedge clk) disable iff (sys_rst)
		(hardRstIn && !mainPorIn) |=> watchdogControl[7:1] == 7'h00
			&& watchdogControl[RWRB_B_WDT_KEEP] == $past(watchdogControl[RWRB_B_WDT_KEEP]);
	endproperty
	a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog control wrong after hard reset");

	property p_dev_lock;
		@(posedge clk) disable iff (sys_rst)
		devLocked |=> $stable(s_ff.slot[RWRB_S_DEV_DIS]);
	endproperty
	a_dev_lock: assert property (p_dev_lock) else $error("locked device disable changed");

	property p_fan_clear;
		@(posedge clk) disable iff (sys_rst)
		(mainPorIn || hardRstIn) |=> !fanOutputLevel;
	endproperty
	a_fan_clear: assert property (p_fan_clear) else $error("fan bit not cleared");

	property p_g43_clear;
		@(posedge clk) disable iff (sys_rst)
		(mainPorIn || hardRstIn) |=> s_ff.slot[RWRB_S_GPIO43][RWRB_B_G43_HI:RWRB_B_G43_LO] == 2'b00;
	endproperty
	a_g43_clear: assert property (p_g43_clear) else $error("gpio 43 bits not cleared");

	property p_prt_idle;
		@(posedge clk) disable iff (sys_rst)
		!s_ff.slot[RWRB_S_PORT_ACT][RWRB_B_PORT_ACT] |-> printerPortIrq;
	endproperty
	a_prt_idle: assert property (p_prt_idle) else $error("printer irq not one while idle");

	property p_prt_track;
		@(posedge clk) disable iff (sys_rst)
		(s_ff.slot[RWRB_S_PORT_ACT][RWRB_B_PORT_ACT] && $past(s_ff.slot[RWRB_S_PORT_ACT][RWRB_B_PORT_ACT], 3))
		|-> printerPortIrq == $past(printerAcknowledgeN, 2);
	endproperty
	a_prt_track: assert property (p_prt_track) else $error("printer irq not tracking ack");

	property p_edge_irq;
		@(posedge clk) disable iff (sys_rst)
		($changed(s_ff.pinSync2) && s_ff.pinWarm[2]) |=> s_ff.irqSts[RWRB_IRQ_EDGE];
	endproperty
	a_edge_irq: assert property (p_edge_irq) else $error("gpio edge not flagged");

	property p_pin_eq;
		@(posedge clk) disable iff (sys_rst)
		(s_ff.wakeFlag && s_ff.wakeGate) |-> !wakeRequestPinN;
	endproperty
	a_pin_eq: assert property (p_pin_eq) else $error("wake pin not asserted");

	property p_gate_write;
		@(posedge clk) disable iff (sys_rst)
		(wrOne && s_ff.awIdx == RWRB_IDX_WAKE_EN) |=> s_ff.wakeGate == $past(s_ff.wData[RWRB_B_WAKE]);
	endproperty
	a_gate_write: assert property (p_gate_write) else $error("wake gate not written");

	property p_src_flag;
		@(posedge clk) disable iff (sys_rst)
		(|(s_ff.slot[RWRB_S_WAKE_STS7] & s_ff.slot[RWRB_S_WAKE_EN7])) |=> s_ff.wakeFlag;
	endproperty
	a_src_flag: assert property (p_src_flag) else $error("wake flag not set by source");

	property p_src_sticky;
		@(posedge clk) disable iff (sys_rst)
		(wakeSourceIn != 8'h00)
		|=> (s_ff.slot[RWRB_S_WAKE_STS7] & $past(wakeSourceIn)) == $past(wakeSourceIn);
	endproperty
	a_src_sticky: assert property (p_src_sticky) else $error("wake source not latched");

	property p_rsvd_bits;
		@(posedge clk) disable iff (sys_rst)
		(rdFire && rdIdx == RWRB_IDX_WAKE_EN) |=> s_axi_rdata[31:1] == 31'h00000000;
	endproperty
	a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved gate bits not zero");

	property p_dev_free;
		@(posedge clk) disable iff (sys_rst)
		(wrOne && s_ff.awIdx == RWRB_IDX_DEV_DIS && !devLocked)
		|=> s_ff.slot[RWRB_S_DEV_DIS] == $past(s_ff.wData);
	endproperty
	a_dev_free: assert property (p_dev_free) else $error("unlocked device disable not written");

	property p_wdt_main;
		@(posedge clk) disable iff (sys_rst)
		mainPorIn |=> watchdogControl == 8'h00;
	endproperty
	a_wdt_main: assert property (p_wdt_main) else $error("watchdog control not cleared");
endmodule

// ==== verification/test_runtime_wake_register_block.sv ====
// testbench: register access, wake pin, reset exceptions, interrupt of the runtime block
`timescale 1ns/1ps

module test_runtime_wake_register_block;
	import rwrb_pkg::*;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mainPorIn = 1'b0;
	logic hardRstIn = 1'b0;
	logic wakeEventIn = 1'b0;
	logic [7:0] wakeSourceIn = 8'h00;
	logic [7:0] fanTachCountIn = 8'h00;
	logic gpioPin43 = 1'b0;
	logic printerAcknowledgeN = 1'b1;
	logic [31:0] s_axi_awaddr = 32'h00000000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [31:0] s_axi_araddr = 32'h00000000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic wakeRequestPinN, printerPortIrq, fanOutputLevel, irq;
	logic [7:0] watchdogControl;
	logic [7:0] rwIdx [15];
	logic [1:0] resp;
	logic [7:0] rdVal;
	int failures = 0;
	int checkCount = 0;
	int cycles = 0;

	rwrb_core u_dut (.clk(clk), .sys_rst(sys_rst), .mainPorIn(mainPorIn), .hardRstIn(hardRstIn),
		.wakeEventIn(wakeEventIn), .wakeSourceIn(wakeSourceIn), .fanTachCountIn(fanTachCountIn),
		.gpioPin43(gpioPin43), .printerAcknowledgeN(printerAcknowledgeN),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.wakeRequestPinN(wakeRequestPinN), .printerPortIrq(printerPortIrq),
		.fanOutputLevel(fanOutputLevel), .watchdogControl(watchdogControl), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic axiWrite(input logic [31:0] addr, input logic [7:0] data);
		logic awPend, wPend, bPend;
		awPend = 1'b1;
		wPend = 1'b1;
		bPend = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= addr;
		s_axi_wdata <= {24'h000000, data};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (awPend || wPend || bPend) begin
			@(posedge clk);
			if (awPend && s_axi_awready) begin
				awPend = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (wPend && s_axi_wready) begin
				wPend = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (bPend && s_axi_bvalid) begin
				bPend = 1'b0;
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask

	task automatic axiRead(input logic [31:0] addr);
		logic arPend, rPend;
		arPend = 1'b1;
		rPend = 1'b1;
		@(posedge clk);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (arPend || rPend) begin
			@(posedge clk);
			if (arPend && s_axi_arready) begin
				arPend = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (rPend && s_axi_rvalid) begin
				rPend = 1'b0;
				resp = s_axi_rresp;
				rdVal = s_axi_rdata[7:0];
				chk("rdata upper", 32'h00000000, {8'h00, s_axi_rdata[31:8]});
				s_axi_rready <= 1'b0;
			end
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		axiWrite({22'h000000, idx, 2'b00}, data);
		chk($sformatf("bresp %h", idx), {30'h0, RWRB_RESP_OKAY}, {30'h0, resp});
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		axiRead({22'h000000, idx, 2'b00});
		chk($sformatf("rresp %h", idx), {30'h0, RWRB_RESP_OKAY}, {30'h0, resp});
		chk($sformatf("reg %h", idx), {24'h0, exp}, {24'h0, rdVal});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rwIdx = '{8'h50, 8'h52, 8'h53, 8'h54, 8'h56, 8'h58, 8'h5B, 8'h5D, 8'h5E, 8'h5F, 8'h60,
			8'h61, 8'h64, 8'h66, 8'h6C};
		cyc(3);
		sys_rst <= 1'b0;
		// reset values and reserved locations
		for (int i = 0; i <= 8'h82; i++) begin
			rdc(i[7:0], (i == 8'h58) ? RWRB_RST_FAN_CTRL : (i == 8'h3E) ? RWRB_RST_GPIO43 : 8'h00);
		end
		chk("pin idle", 32'h1, {31'h0, wakeRequestPinN});
		for (int i = 0; i < 15; i++) begin
			wr(rwIdx[i], rwIdx[i] ^ 8'hA5);
			rdc(rwIdx[i], rwIdx[i] ^ 8'hA5);
		end
		wr(RWRB_IDX_WAKE_EN, 8'hFF);
		rdc(RWRB_IDX_WAKE_EN, 8'h01);
		wr(RWRB_IDX_RSVD, 8'hFF);
		rdc(RWRB_IDX_RSVD, 8'h00);
		axiRead(32'h0000020C);
		chk("rresp unmapped", {30'h0, RWRB_RESP_SLVERR}, {30'h0, resp});
		axiWrite(32'h00000400, 8'h11);
		chk("bresp unmapped", {30'h0, RWRB_RESP_SLVERR}, {30'h0, resp});
		fanTachCountIn <= 8'hC3;
		wr(RWRB_IDX_FAN_TACH, 8'h00);
		rdc(RWRB_IDX_FAN_TACH, 8'hC3);
		$display("test registers done");
		// wake flag, gate and pin
		wr(RWRB_IDX_WAKE_EN, 8'h00);
		wakeEventIn <= 1'b1;
		cyc(1);
		wakeEventIn <= 1'b0;
		cyc(2);
		chk("pin gated", 32'h1, {31'h0, wakeRequestPinN});
		rdc(RWRB_IDX_WAKE_STS, 8'h01);
		wr(RWRB_IDX_WAKE_STS, 8'h00);
		rdc(RWRB_IDX_WAKE_STS, 8'h01);
		wr(RWRB_IDX_WAKE_EN, 8'h01);
		cyc(1);
		chk("pin active", 32'h0, {31'h0, wakeRequestPinN});
		mainPorIn <= 1'b1;
		cyc(1);
		mainPorIn <= 1'b0;
		hardRstIn <= 1'b1;
		cyc(1);
		hardRstIn <= 1'b0;
		cyc(2);
		chk("pin kept", 32'h0, {31'h0, wakeRequestPinN});
		rdc(RWRB_IDX_WAKE_STS, 8'h01);
		rdc(RWRB_IDX_WAKE_EN, 8'h01);
		wr(RWRB_IDX_WAKE_STS, 8'h01);
		cyc(1);
		chk("pin released", 32'h1, {31'h0, wakeRequestPinN});
		rdc(RWRB_IDX_WAKE_STS, 8'h00);
		wr(RWRB_IDX_WAKE_EN7, 8'h04);
		wakeSourceIn <= 8'h04;
		cyc(1);
		wakeSourceIn <= 8'h00;
		cyc(2);
		chk("pin by source", 32'h0, {31'h0, wakeRequestPinN});
		wr(RWRB_IDX_WAKE_STS7, 8'h04);
		wr(RWRB_IDX_WAKE_STS, 8'h01);
		cyc(1);
		chk("pin cleared", 32'h1, {31'h0, wakeRequestPinN});
		$display("test wake done");
		// hard and main power-on reset exceptions
		wr(RWRB_IDX_WDT_CONTROL, 8'hFF);
		wr(RWRB_IDX_GPIO3, 8'h0F);
		wr(RWRB_IDX_GPIO43, 8'h0C);
		wr(RWRB_IDX_GPIO6, 8'h5A);
		chk("fan level", 32'h1, {31'h0, fanOutputLevel});
		hardRstIn <= 1'b1;
		cyc(1);
		hardRstIn <= 1'b0;
		cyc(2);
		chk("wdt port", 32'h01, {24'h0, watchdogControl});
		rdc(RWRB_IDX_WDT_CONTROL, 8'h01);
		rdc(RWRB_IDX_WDT_TMO, 8'h00);
		rdc(RWRB_IDX_GPIO3, 8'h07);
		chk("fan level", 32'h0, {31'h0, fanOutputLevel});
		rdc(RWRB_IDX_GPIO43, 8'h00);
		rdc(RWRB_IDX_GPIO6, 8'h5A);
		mainPorIn <= 1'b1;
		cyc(1);
		mainPorIn <= 1'b0;
		rdc(RWRB_IDX_WDT_CONTROL, 8'h00);
		$display("test reset exceptions done");
		// device disable lock
		wr(RWRB_IDX_GPIO43, 8'h05);
		gpioPin43 <= 1'b1;
		cyc(4);
		wr(RWRB_IDX_DEV_DIS, 8'hAA);
		rdc(RWRB_IDX_DEV_DIS, 8'h00);
		gpioPin43 <= 1'b0;
		cyc(4);
		wr(RWRB_IDX_DEV_DIS, 8'hAA);
		rdc(RWRB_IDX_DEV_DIS, 8'hAA);
		wr(RWRB_IDX_GPIO43, 8'h0D);
		gpioPin43 <= 1'b1;
		cyc(4);
		wr(RWRB_IDX_DEV_DIS, 8'h55);
		rdc(RWRB_IDX_DEV_DIS, 8'h55);
		$display("test lock done");
		// interrupt status, mask and gpio edges
		wr(RWRB_IDX_IRQ_MASK, 8'hFC);
		rdc(RWRB_IDX_IRQ_MASK, 8'h00);
		wr(RWRB_IDX_IRQ_STS, 8'hFF);
		rdc(RWRB_IDX_IRQ_STS, 8'h00);
		gpioPin43 <= 1'b0;
		cyc(4);
		rdc(RWRB_IDX_IRQ_STS, 8'h02);
		wr(RWRB_IDX_IRQ_STS, 8'h02);
		wr(RWRB_IDX_GPIO43, 8'h03);
		gpioPin43 <= 1'b1;
		cyc(4);
		rdc(RWRB_IDX_IRQ_STS, 8'h02);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(RWRB_IDX_IRQ_MASK, 8'h02);
		cyc(1);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(RWRB_IDX_IRQ_STS, 8'h02);
		cyc(1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wakeEventIn <= 1'b1;
		cyc(1);
		wakeEventIn <= 1'b0;
		cyc(2);
		rdc(RWRB_IDX_IRQ_STS, 8'h01);
		wr(RWRB_IDX_IRQ_MASK, 8'h01);
		cyc(1);
		chk("irq wake", 32'h1, {31'h0, irq});
		wr(RWRB_IDX_IRQ_STS, 8'h01);
		cyc(1);
		chk("irq wake cleared", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		// printer port interrupt status
		printerAcknowledgeN <= 1'b0;
		cyc(4);
		chk("port idle", 32'h1, {31'h0, printerPortIrq});
		wr(RWRB_IDX_PORT_ACT, 8'h01);
		cyc(4);
		chk("port ack low", 32'h0, {31'h0, printerPortIrq});
		printerAcknowledgeN <= 1'b1;
		cyc(4);
		chk("port ack high", 32'h1, {31'h0, printerPortIrq});
		$display("test printer done");
		// standby power-on reset in mid-run clears wake flag and gate
		chk("pin before standby reset", 32'h0, {31'h0, wakeRequestPinN});
		sys_rst <= 1'b1;
		cyc(3);
		sys_rst <= 1'b0;
		rdc(RWRB_IDX_WAKE_STS, 8'h00);
		rdc(RWRB_IDX_WAKE_EN, 8'h00);
		rdc(RWRB_IDX_IRQ_STS, 8'h00);
		chk("pin after standby reset", 32'h1, {31'h0, wakeRequestPinN});
		$display("test standby reset done");
		print_verdict();
	end
endmodule
